/* File: hdl/apt_map.vh */
`ifndef APT_MAP_VH
`define APT_MAP_VH
// ==========================================================================
// Register offsets on the serial control port.
`define APT_OFS_POWER_MODE 8'h37
`define APT_OFS_TIMESTAMP 8'h3b
`define APT_OFS_REF_OUT 8'h3c
`define APT_OFS_FBDIV_VP 8'h3d
`define APT_OFS_FBDIV_N 8'h3e
// ==========================================================================
// Reset values.
`define APT_RST_POWER_MODE 8'h4b
`define APT_RST_TIMESTAMP 8'h00
`define APT_RST_REF_OUT 8'h01
`define APT_RST_FBDIV_VP 8'h00
`define APT_RST_FBDIV_N 8'h20
// ==========================================================================
// Power mode codes.
`define APT_PM_LOW_POWER 8'h46
`define APT_PM_HIGH_PERF 8'h4b
// ==========================================================================
// Field positions.
`define APT_TS_EN_BIT 0
`define APT_REF_EN_BIT 0
`define APT_P_DIV_MSB 3
`define APT_P_DIV_LSB 2
`define APT_V_DIV_MSB 1
`define APT_V_DIV_LSB 0
`define APT_N_DIV_MSB 5
`define APT_N_DIV_LSB 0
`endif

/* File: hdl/apt_reg8.v */
`timescale 1ns/100ps
// One 8-bit read/write register with its own reset value.
module apt_reg8 #(
	parameter [7:0] RESET_VALUE = 8'h00
) (
	input wire clk, // Core clock.
	input wire nrst, // Asynchronous reset, active low.
	input wire we, // Write strobe.
	input wire [7:0] wdata, // Write data.
	output reg [7:0] q // Stored value.
);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= RESET_VALUE;
		end else if (we) begin
			q <= wdata;
		end
	end
endmodule

/* File: hdl/apt_config.v */
`timescale 1ns/100ps
`include "apt_map.vh"
module apt_config (
	input wire CORE_CLK, // Core clock, 125 MHz.
	input wire NRST, // Asynchronous reset, active low.
	input wire WR_EN, // Control port write strobe, one cycle.
	input wire RD_EN, // Control port read strobe, one cycle.
	input wire [7:0] ADDR, // Register offset.
	input wire [7:0] WDATA, // Write data.
	input wire PLL_EN, // PLL enable pin.
	output reg [7:0] RDATA, // Read data, registered.
	output reg RD_VALID, // Read data valid, one cycle.
	output wire LOW_POWER_MODE, // Low power operation selected.
	output wire HIGH_PERF_MODE, // High performance operation selected.
	output wire POWER_MODE_RESERVED, // Power mode code is reserved.
	output wire TIMESTAMP_RECEIVER_ENABLE, // Timestamp input receiver on.
	output wire REF_CLOCK_OUTPUT_ENABLE, // Reference clock output driven.
	output reg [2:0] V_DIV_RATIO, // First divider ratio, 0 when reserved.
	output reg [2:0] P_DIV_RATIO, // Second divider ratio, 0 when reserved.
	output wire [5:0] N_DIV_RATIO, // Third divider ratio.
	output wire DIV_CODE_RESERVED // A divider holds a reserved or zero code.
);
	// ======================================================================
	// Register storage.
	wire [7:0] power_mode_select;
	wire [7:0] timestamp_input_control;
	wire [7:0] reference_output_control;
	wire [7:0] synth_feedback_div_first_second;
	wire [7:0] synth_feedback_div_third;
	wire we_pm = WR_EN && (ADDR == `APT_OFS_POWER_MODE);
	wire we_ts = WR_EN && (ADDR == `APT_OFS_TIMESTAMP);
	wire we_ro = WR_EN && (ADDR == `APT_OFS_REF_OUT);
	wire we_vp = WR_EN && (ADDR == `APT_OFS_FBDIV_VP);
	wire we_n = WR_EN && (ADDR == `APT_OFS_FBDIV_N);

	// Reserved bits are stored as written so readback is exact.
	// Keeping them costs a few flip-flops but lets the host verify that it
	// wrote the reset values back into the reserved fields.
	apt_reg8 #(.RESET_VALUE(`APT_RST_POWER_MODE)) u_pm (
		.clk(CORE_CLK),
		.nrst(NRST),
		.we(we_pm),
		.wdata(WDATA),
		.q(power_mode_select)
	);
	apt_reg8 #(.RESET_VALUE(`APT_RST_TIMESTAMP)) u_ts (
		.clk(CORE_CLK),
		.nrst(NRST),
		.we(we_ts),
		.wdata(WDATA),
		.q(timestamp_input_control)
	);
	apt_reg8 #(.RESET_VALUE(`APT_RST_REF_OUT)) u_ro (
		.clk(CORE_CLK),
		.nrst(NRST),
		.we(we_ro),
		.wdata(WDATA),
		.q(reference_output_control)
	);
	apt_reg8 #(.RESET_VALUE(`APT_RST_FBDIV_VP)) u_vp (
		.clk(CORE_CLK),
		.nrst(NRST),
		.we(we_vp),
		.wdata(WDATA),
		.q(synth_feedback_div_first_second)
	);
	apt_reg8 #(.RESET_VALUE(`APT_RST_FBDIV_N)) u_n (
		.clk(CORE_CLK),
		.nrst(NRST),
		.we(we_n),
		.wdata(WDATA),
		.q(synth_feedback_div_third)
	);

	// ======================================================================
	// Read path.
	reg [7:0] next_rdata;
	always @* begin
		case (ADDR)
			`APT_OFS_POWER_MODE: next_rdata = power_mode_select;
			`APT_OFS_TIMESTAMP: next_rdata = timestamp_input_control;
			`APT_OFS_REF_OUT: next_rdata = reference_output_control;
			`APT_OFS_FBDIV_VP: next_rdata = synth_feedback_div_first_second;
			`APT_OFS_FBDIV_N: next_rdata = synth_feedback_div_third;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 8'h00;
			RD_VALID <= 1'b0;
		end else begin
			RD_VALID <= RD_EN;
			if (RD_EN) begin
				RDATA <= next_rdata;
			end
		end
	end

	// ======================================================================
	// Power mode decode. A reserved code selects neither mode, so the core
	// keeps no guessed setting for it.
	assign LOW_POWER_MODE = (power_mode_select == `APT_PM_LOW_POWER);
	assign HIGH_PERF_MODE = (power_mode_select == `APT_PM_HIGH_PERF);
	assign POWER_MODE_RESERVED = !LOW_POWER_MODE && !HIGH_PERF_MODE;

	// ======================================================================
	// Timestamp receiver and reference output.
	assign TIMESTAMP_RECEIVER_ENABLE = timestamp_input_control[`APT_TS_EN_BIT];
	assign REF_CLOCK_OUTPUT_ENABLE = reference_output_control[`APT_REF_EN_BIT] && PLL_EN;

	// ======================================================================
	// Feedback divider ratios.
	wire [1:0] v_code = synth_feedback_div_first_second[`APT_V_DIV_MSB:`APT_V_DIV_LSB];
	wire [1:0] p_code = synth_feedback_div_first_second[`APT_P_DIV_MSB:`APT_P_DIV_LSB];
	always @* begin
		case (v_code)
			2'h0: V_DIV_RATIO = 3'h5;
			2'h1: V_DIV_RATIO = 3'h4;
			2'h2: V_DIV_RATIO = 3'h3;
			default: V_DIV_RATIO = 3'h0;
		endcase
	end
	always @* begin
		case (p_code)
			2'h0: P_DIV_RATIO = 3'h1;
			2'h1: P_DIV_RATIO = 3'h2;
			2'h2: P_DIV_RATIO = 3'h4;
			default: P_DIV_RATIO = 3'h0;
		endcase
	end
	assign N_DIV_RATIO = synth_feedback_div_third[`APT_N_DIV_MSB:`APT_N_DIV_LSB];
	// Zero is not a supported third divider value.
	assign DIV_CODE_RESERVED = (V_DIV_RATIO == 3'h0) || (P_DIV_RATIO == 3'h0) || (N_DIV_RATIO == 6'h00);
endmodule

/* File: testbench/apt_config_properties.sv */
`timescale 1ns/100ps
// ====
// Port checks of the register block.
module apt_props (
	input wire CORE_CLK, // Clock.
	input wire NRST, // Reset.
	input wire WR_EN, // Write.
	input wire RD_EN, // Read.
	input wire [7:0] ADDR, // Offset.
	input wire [7:0] WDATA, // Data.
	input wire PLL_EN, // Pin.
	input wire RD_VALID, // Valid.
	input wire LOW_POWER_MODE, // Low.
	input wire HIGH_PERF_MODE, // High.
	input wire TIMESTAMP_RECEIVER_ENABLE, // Stamp.
	input wire REF_CLOCK_OUTPUT_ENABLE, // Ref.
	input wire [2:0] V_DIV_RATIO, // First.
	input wire [2:0] P_DIV_RATIO // Second.
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	a_read_valid: assert property (RD_EN |=> RD_VALID) else $error("read gave no valid");
	a_valid_cause: assert property (RD_VALID |-> $past(RD_EN)) else $error("valid without read");
	a_stamp_write: assert property (WR_EN && ADDR == 8'h3b |=>
		TIMESTAMP_RECEIVER_ENABLE == $past(WDATA[0])) else $error("stamp enable wrong");
	a_ref_gate: assert property (REF_CLOCK_OUTPUT_ENABLE |-> PLL_EN) else $error("ref out w/o pll");
	a_low_code: assert property (WR_EN && ADDR == 8'h37 && WDATA == 8'h46 |=>
		LOW_POWER_MODE && !HIGH_PERF_MODE) else $error("low code wrong");
	a_high_code: assert property (WR_EN && ADDR == 8'h37 && WDATA == 8'h4b |=>
		HIGH_PERF_MODE && !LOW_POWER_MODE) else $error("high code wrong");
	a_first_div: assert property (WR_EN && ADDR == 8'h3d && WDATA[1:0] == 2'h2 |=>
		V_DIV_RATIO == 3'h3) else $error("first ratio wrong");
	a_second_div: assert property (WR_EN && ADDR == 8'h3d && WDATA[3:2] == 2'h2 |=>
		P_DIV_RATIO == 3'h4) else $error("second ratio wrong");
endmodule

/* File: testbench/apt_config_bench.sv */
`timescale 1ns/100ps
// ====
// Register block bench; a second reset in mid-run repeats the whole pass.
module apt_config_bench;
	logic CORE_CLK = 0, NRST = 0, WR_EN = 0, RD_EN = 0, PLL_EN = 1;
	logic [7:0] ADDR = 0, WDATA = 0;
	wire [7:0] RDATA;
	wire RD_VALID, LOW_POWER_MODE, HIGH_PERF_MODE, POWER_MODE_RESERVED, DIV_CODE_RESERVED;
	wire TIMESTAMP_RECEIVER_ENABLE, REF_CLOCK_OUTPUT_ENABLE;
	wire [2:0] V_DIV_RATIO, P_DIV_RATIO;
	wire [5:0] N_DIV_RATIO;
	int n_mismatch = 0, comparisons = 0;
	logic [7:0] ofs[5] = '{8'h37, 8'h3b, 8'h3c, 8'h3d, 8'h3e}, rst[5] = '{8'h4b, 8'h00, 8'h01, 8'h00, 8'h20};
	// Write values keep every reserved field at its reset value except timestamp bit 1, which is written as 1.
	logic [7:0] wv[5] = '{8'h46, 8'h03, 8'h00, 8'h0a, 8'h3f};
	logic [7:0] pm[3] = '{8'h46, 8'h4b, 8'h5a}, pe[3] = '{8'h04, 8'h02, 8'h01}, nv[2] = '{8'h01, 8'h3f};
	logic [2:0] vr[4] = '{3'h5, 3'h4, 3'h3, 3'h0}, pr[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
	apt_config i_dut (.*);
	task chk(input logic [7:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge CORE_CLK);
		#1 {WR_EN, ADDR, WDATA} = {1'b1, a, d};
		@(posedge CORE_CLK);
		#1 WR_EN = 0;
	endtask
	// Read data lands one edge after the strobe, so it is compared then.
	task rd(input logic [7:0] a, e);
		@(posedge CORE_CLK);
		#1 {RD_EN, ADDR} = {1'b1, a};
		@(posedge CORE_CLK);
		#1 RD_EN = 0;
		chk({7'h0, RD_VALID}, 8'h01);
		chk(RDATA, e);
	endtask
	task test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		repeat (2) @(posedge CORE_CLK);
		#1 NRST = 1;
		for (int r = 0; r < 2; r++) begin
			chk(RDATA, 8'h00);
			foreach (ofs[i]) rd(ofs[i], rst[i]);
			chk({1'b0, HIGH_PERF_MODE, V_DIV_RATIO, P_DIV_RATIO}, 8'h69);
			chk({2'h0, N_DIV_RATIO}, 8'h20);
			foreach (ofs[i]) wr(ofs[i], wv[i]);
			foreach (ofs[i]) rd(ofs[i], wv[i]);
			rd(8'h40, 8'h00);
			foreach (pm[i]) begin
				wr(8'h37, pm[i]);
				chk({5'h0, LOW_POWER_MODE, HIGH_PERF_MODE, POWER_MODE_RESERVED}, pe[i]);
			end
			for (int v = 0; v < 4; v++) begin
				wr(8'h3d, 8'(v) | 8'(12 - 4 * v));
				chk({2'h0, V_DIV_RATIO, P_DIV_RATIO}, {2'h0, vr[v], pr[3 - v]});
				chk({7'h0, DIV_CODE_RESERVED}, {7'h0, v == 0 || v == 3});
			end
			foreach (nv[i]) begin
				wr(8'h3e, nv[i]);
				chk({2'h0, N_DIV_RATIO}, {2'h0, nv[i][5:0]});
			end
			for (int b = 0; b < 8; b++) begin
				wr(8'h3b, {7'h0, b[0]});
				wr(8'h3c, {7'h0, b[1]});
				PLL_EN = b[2];
				#1 chk({6'h0, TIMESTAMP_RECEIVER_ENABLE, REF_CLOCK_OUTPUT_ENABLE}, {6'h0, b[0], b[1] & b[2]});
			end
			@(posedge CORE_CLK);
			#1 NRST = 0;
			@(posedge CORE_CLK);
			#1 NRST = 1;
		end
		test_done;
	end
endmodule
bind apt_config apt_props i_props (.*);
